/* pkg/stim_one_pkg.sv */
// Purpose: constants and types for the stimulus one step of the custom emulation profile
// Assumes: 25 MHz core clock, byte-wide register port
// Notes: analog levels are carried as codes in millivolts, hundreds of ohms, ohms and kilohms
package stim_one_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam logic [7:0] SRC_TIMER_ADDR = 8'h41;
    localparam logic [7:0] RESPONSE_ADDR = 8'h42;
    localparam logic [7:0] SRC_TIMER_RESET = 8'h00;
    localparam logic [7:0] RESPONSE_RESET = 8'h00;
    localparam logic [7:0] SRC_TIMER_MASK = 8'h7f;
    // field positions
    localparam int SRC_LSB = 0;
    localparam int DELAY_LSB = 3;
    localparam int KIND_BIT = 6;
    localparam int ACT_LSB = 0;
    localparam int MAG_LSB = 4;
    // source codes
    localparam logic [2:0] SRC_VBUS_READY = 3'h0;
    localparam logic [2:0] SRC_DP_ABOVE = 3'h1;
    localparam logic [2:0] SRC_DP_WINDOW = 3'h2;
    localparam logic [2:0] SRC_DM_ABOVE = 3'h3;
    localparam logic [2:0] SRC_RSVD_A = 3'h4;
    localparam logic [2:0] SRC_RSVD_B = 3'h5;
    localparam logic [2:0] SRC_DP_ABOVE_ALT = 3'h6;
    localparam logic [2:0] SRC_VBUS_PRESENT = 3'h7;
    // action codes
    localparam logic [3:0] ACT_REMOVE = 4'h0;
    localparam logic [3:0] ACT_V_DP = 4'h1;
    localparam logic [3:0] ACT_V_DM = 4'h2;
    localparam logic [3:0] ACT_V_BOTH = 4'h3;
    localparam logic [3:0] ACT_R_DP = 4'h4;
    localparam logic [3:0] ACT_RSVD_5 = 4'h5;
    localparam logic [3:0] ACT_DIV_DP = 4'h6;
    localparam logic [3:0] ACT_R_DM = 4'h7;
    localparam logic [3:0] ACT_RSVD_8 = 4'h8;
    localparam logic [3:0] ACT_DIV_DM = 4'h9;
    localparam logic [3:0] ACT_SHORT = 4'ha;
    localparam logic [3:0] ACT_RSVD_B = 4'hb;
    localparam logic [3:0] ACT_DIV_BOTH = 4'hc;
    localparam logic [3:0] ACT_R_BOTH = 4'hd;
    localparam logic [3:0] ACT_KEEP_E = 4'he;
    localparam logic [3:0] ACT_KEEP_F = 4'hf;
    localparam logic [3:0] MAG_RSVD = 4'hf;
    localparam logic [3:0] MAG_PULLDOWN = 4'h0;
    localparam logic [15:0] FIXED_WINDOW_LOW_MV = 16'h0190;
    localparam logic [15:0] SHORT_MAX_OHM = 16'h00c8;

    typedef enum {IDLE, WAIT_DELAY, APPLIED, HOLDING, DONE} step_state_t;
    typedef enum {LINE_NONE, LINE_EMU_PD, LINE_VOLT, LINE_RES, LINE_DIV, LINE_SHORT} line_kind_t;

    // one data line's commanded analog state
    typedef struct packed {
        logic [2:0] kind;
        logic [15:0] value;
    } line_drive_t;

    // analog comparator results; the raw inputs are asynchronous until they pass the synchroniser
    typedef struct packed {
        logic vbus_ready;
        logic vbus_present;
        logic dp_above_th;
        logic dp_above_fixed;
        logic dm_above_th;
    } sense_t;
endpackage

/* design/stim_one.sv */
// Purpose: stimulus one configuration registers and response sequencing
// Assumes: comparator inputs come from the analog front end asynchronously
// Notes: analog response is described by kind and value codes per data line
`timescale 1ns/1ps

// Notes on behaviour
// - source/timer register bit 7 reads zero
// - kind one applies at once, holds, releases
// - kind zero waits the timer, then responds
// - delay select maps to eight millisecond values
// - source 000 is vbus ready, not awaited (the step still waits for vbus_ready to rise and, for kind one, to fall)
// - 001/110 watch D+, 011 watches D-
// - 010 is D+ between 400 mV and threshold
// - source 111 is vbus present, not awaited (the step still waits for vbus_present to rise and, for kind one, to fall)
// - writes with reserved codes leave field unchanged
// - magnitude meaning follows the response type
// - voltage magnitude decode, pull-down to 2200 mV
// - resistor magnitude decode 1.8k to 150k
// - divider magnitude decode, minimum total resistance
// - action 0000 removes responses on both lines
// - actions 0001-0011 drive voltage D+, D-, both
// - resistor to ground actions, plus line short
// - divider actions with midpoint on lines
// - actions 1110/1111 keep or drop emulation pull-downs
// - source 000 keeps untouched line's emulation pull-down
// - threshold ignored for vbus sources
module stim_one #(
    parameter int MS_CYCLES = stim_one_pkg::MS_CYCLES
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic step_start_i,
    input wire stim_one_pkg::sense_t sense_i,
    output logic stimulus_seen_o,
    output logic step_done_o,
    output stim_one_pkg::line_drive_t port_dplus_line_o,
    output stim_one_pkg::line_drive_t port_dminus_line_o
);
    initial begin
        if (MS_CYCLES < 1) begin
            $error("MS_CYCLES must be at least one");
        end
    end

    logic stimulus_one_timer_kind;
    logic [2:0] stimulus_one_delay_sel;
    logic [2:0] stimulus_one_source_sel;
    logic [3:0] response_one_magnitude;
    logic [3:0] response_one_action;
    stim_one_pkg::sense_t s1;
    stim_one_pkg::sense_t s2;
    stim_one_pkg::sense_t s3;
    stim_one_pkg::sense_t sense_q;
    stim_one_pkg::step_state_t state;
    logic [31:0] ms_div;
    logic [6:0] ms_count;
    logic stim_hit;
    logic [6:0] delay_ms;
    logic tick;
    logic dp_touched;
    logic dm_touched;

    // stimulus_delay_time per select code, in ms
    function automatic logic [6:0] delay_ms_of(input logic [2:0] sel);
        case (sel)
            3'h0: delay_ms_of = 7'h00;
            3'h1: delay_ms_of = 7'h01;
            3'h2: delay_ms_of = 7'h05;
            3'h3: delay_ms_of = 7'h0a;
            3'h4: delay_ms_of = 7'h14;
            3'h5: delay_ms_of = 7'h28;
            3'h6: delay_ms_of = 7'h50;
            default: delay_ms_of = 7'h64;
        endcase
    endfunction

    function automatic logic src_reserved(input logic [2:0] s);
        src_reserved = (s == stim_one_pkg::SRC_RSVD_A) || (s == stim_one_pkg::SRC_RSVD_B);
    endfunction

    function automatic logic act_reserved(input logic [3:0] a);
        act_reserved = (a == stim_one_pkg::ACT_RSVD_5) || (a == stim_one_pkg::ACT_RSVD_8)
            || (a == stim_one_pkg::ACT_RSVD_B);
    endfunction

    // voltage level in mV for a magnitude code
    function automatic logic [15:0] volt_mv(input logic [3:0] m);
        case (m)
            4'h0: volt_mv = 16'h0000;
            4'h1, 4'h2, 4'h3, 4'h4: volt_mv = 16'h0190;
            4'h5: volt_mv = 16'h01f4;
            4'h6: volt_mv = 16'h0258;
            4'h7: volt_mv = 16'h02bc;
            4'h8: volt_mv = 16'h0320;
            4'h9: volt_mv = 16'h0384;
            4'ha: volt_mv = 16'h0578;
            4'hb: volt_mv = 16'h0640;
            4'hc: volt_mv = 16'h0708;
            4'hd: volt_mv = 16'h07d0;
            default: volt_mv = 16'h0898;
        endcase
    endfunction

    // resistor in hundreds of ohms
    function automatic logic [15:0] res_hohm(input logic [3:0] m);
        case (m)
            4'h0: res_hohm = 16'h0012;
            4'h1: res_hohm = 16'h0064;
            4'h2: res_hohm = 16'h0096;
            4'h3: res_hohm = 16'h00c8;
            4'h4: res_hohm = 16'h00fa;
            4'h5: res_hohm = 16'h012c;
            4'h6: res_hohm = 16'h0190;
            4'h7: res_hohm = 16'h01ae;
            4'h8: res_hohm = 16'h01f4;
            4'h9: res_hohm = 16'h0258;
            4'ha: res_hohm = 16'h02ee;
            4'hb: res_hohm = 16'h0320;
            4'hc: res_hohm = 16'h03e8;
            4'hd: res_hohm = 16'h04b0;
            default: res_hohm = 16'h05dc;
        endcase
    endfunction

    // divider minimum total in kilohm; low codes of each group of eight
    function automatic logic [15:0] div_kohm(input logic [3:0] m);
        case (m[2:0])
            3'h0: div_kohm = 16'h005d;
            3'h1: div_kohm = 16'h0064;
            3'h2: div_kohm = 16'h007d;
            3'h3: div_kohm = 16'h0096;
            default: div_kohm = 16'h00c8;
        endcase
    endfunction

    // register writes; reserved codes rejected per field
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            stimulus_one_timer_kind <= 1'b0;
            stimulus_one_delay_sel <= 3'h0;
            stimulus_one_source_sel <= 3'h0;
            response_one_magnitude <= 4'h0;
            response_one_action <= 4'h0;
        end else if (ce_i && reg_wr_i) begin
            if (reg_addr_i == stim_one_pkg::SRC_TIMER_ADDR) begin
                stimulus_one_timer_kind <= reg_wdata_i[stim_one_pkg::KIND_BIT];
                stimulus_one_delay_sel <= reg_wdata_i[stim_one_pkg::DELAY_LSB +: 3];
                if (!src_reserved(reg_wdata_i[stim_one_pkg::SRC_LSB +: 3])) begin
                    stimulus_one_source_sel <= reg_wdata_i[stim_one_pkg::SRC_LSB +: 3];
                end
            end else if (reg_addr_i == stim_one_pkg::RESPONSE_ADDR) begin
                if (!act_reserved(reg_wdata_i[stim_one_pkg::ACT_LSB +: 4])) begin
                    response_one_action <= reg_wdata_i[stim_one_pkg::ACT_LSB +: 4];
                end
                if (reg_wdata_i[stim_one_pkg::MAG_LSB +: 4] != stim_one_pkg::MAG_RSVD) begin
                    response_one_magnitude <= reg_wdata_i[stim_one_pkg::MAG_LSB +: 4];
                end
            end
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        reg_rdata_o = 8'h00;
        if (reg_addr_i == stim_one_pkg::SRC_TIMER_ADDR) begin
            reg_rdata_o = {1'b0, stimulus_one_timer_kind, stimulus_one_delay_sel,
                stimulus_one_source_sel};
        end else if (reg_addr_i == stim_one_pkg::RESPONSE_ADDR) begin
            reg_rdata_o = {response_one_magnitude, response_one_action};
        end
    end

    // three-stage synchroniser; only stages two and three are compared
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            sense_q <= '0;
        end else if (ce_i) begin
            s1 <= sense_i;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < $bits(stim_one_pkg::sense_t); i++) begin
                if (s2[i] == s3[i]) begin
                    sense_q[i] <= s3[i];
                end
            end
        end
    end

    // stimulus decode; threshold comparisons unused for vbus sources
    always_comb begin
        case (stimulus_one_source_sel)
            stim_one_pkg::SRC_VBUS_READY: stim_hit = sense_q.vbus_ready;
            stim_one_pkg::SRC_DP_ABOVE, stim_one_pkg::SRC_DP_ABOVE_ALT:
                stim_hit = sense_q.dp_above_th;
            stim_one_pkg::SRC_DP_WINDOW:
                stim_hit = sense_q.dp_above_fixed && !sense_q.dp_above_th;
            stim_one_pkg::SRC_DM_ABOVE: stim_hit = sense_q.dm_above_th;
            stim_one_pkg::SRC_VBUS_PRESENT: stim_hit = sense_q.vbus_present;
            default: stim_hit = 1'b0;
        endcase
    end

    assign delay_ms = delay_ms_of(stimulus_one_delay_sel);
    assign tick = (ms_div == 32'(MS_CYCLES - 1));

    // step sequencer; kind one finishes once the delay has run and the stimulus is removed, vbus sources included
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= stim_one_pkg::IDLE;
            ms_div <= 32'h0;
            ms_count <= 7'h00;
        end else if (ce_i) begin
            ms_div <= tick ? 32'h0 : ms_div + 32'h1;
            case (state)
                stim_one_pkg::IDLE: begin
                    if (step_start_i && stim_hit) begin
                        ms_div <= 32'h0;
                        ms_count <= 7'h00;
                        if (stimulus_one_timer_kind) begin
                            state <= stim_one_pkg::HOLDING;
                        end else if (delay_ms == 7'h00) begin
                            state <= stim_one_pkg::APPLIED;
                        end else begin
                            state <= stim_one_pkg::WAIT_DELAY;
                        end
                    end
                end
                stim_one_pkg::WAIT_DELAY: begin
                    if (tick) begin
                        ms_count <= ms_count + 7'h01;
                        if (ms_count + 7'h01 >= delay_ms) begin
                            state <= stim_one_pkg::APPLIED;
                        end
                    end
                end
                stim_one_pkg::HOLDING: begin
                    if (tick && ms_count < delay_ms) begin
                        ms_count <= ms_count + 7'h01;
                    end
                    if (ms_count >= delay_ms && !stim_hit) begin
                        state <= stim_one_pkg::DONE;
                    end
                end
                stim_one_pkg::APPLIED: state <= stim_one_pkg::DONE;
                default: begin
                    if (!step_start_i) begin
                        state <= stim_one_pkg::IDLE;
                    end
                end
            endcase
        end
    end

    assign stimulus_seen_o = (state != stim_one_pkg::IDLE);
    assign step_done_o = (state == stim_one_pkg::DONE);

    // which lines the action touches
    always_comb begin
        dp_touched = 1'b0;
        dm_touched = 1'b0;
        case (response_one_action)
            stim_one_pkg::ACT_V_DP, stim_one_pkg::ACT_R_DP, stim_one_pkg::ACT_DIV_DP:
                dp_touched = 1'b1;
            stim_one_pkg::ACT_V_DM, stim_one_pkg::ACT_R_DM, stim_one_pkg::ACT_DIV_DM:
                dm_touched = 1'b1;
            stim_one_pkg::ACT_V_BOTH, stim_one_pkg::ACT_DIV_BOTH, stim_one_pkg::ACT_R_BOTH,
            stim_one_pkg::ACT_SHORT, stim_one_pkg::ACT_REMOVE: begin
                dp_touched = 1'b1;
                dm_touched = 1'b1;
            end
            default: ;
        endcase
    end

    // line drive; emulation pull-downs loaded at reset, response applied in APPLIED or at kind-one step entry
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            port_dplus_line_o <= '{3'(stim_one_pkg::LINE_EMU_PD), 16'h0000};
            port_dminus_line_o <= '{3'(stim_one_pkg::LINE_EMU_PD), 16'h0000};
        end else if (ce_i && (state == stim_one_pkg::APPLIED
                || (state == stim_one_pkg::IDLE && step_start_i && stim_hit
                    && stimulus_one_timer_kind))) begin
            if (response_one_action == stim_one_pkg::ACT_KEEP_E
                    || response_one_action == stim_one_pkg::ACT_KEEP_F) begin
                if (stimulus_one_source_sel == stim_one_pkg::SRC_VBUS_PRESENT) begin
                    port_dplus_line_o <= '{3'(stim_one_pkg::LINE_NONE), 16'h0000};
                    port_dminus_line_o <= '{3'(stim_one_pkg::LINE_NONE), 16'h0000};
                end
            end else begin
                if (dp_touched) begin
                    port_dplus_line_o <= drive_of(response_one_action, response_one_magnitude);
                end else if (stimulus_one_source_sel != stim_one_pkg::SRC_VBUS_READY
                        && port_dplus_line_o.kind == 3'(stim_one_pkg::LINE_EMU_PD)) begin
                    port_dplus_line_o <= '{3'(stim_one_pkg::LINE_NONE), 16'h0000};
                end
                if (dm_touched) begin
                    port_dminus_line_o <= drive_of(response_one_action, response_one_magnitude);
                end else if (stimulus_one_source_sel != stim_one_pkg::SRC_VBUS_READY
                        && port_dminus_line_o.kind == 3'(stim_one_pkg::LINE_EMU_PD)) begin
                    port_dminus_line_o <= '{3'(stim_one_pkg::LINE_NONE), 16'h0000};
                end
            end
        end
    end

    // per-line drive for an action; magnitude meaning follows the type
    function automatic stim_one_pkg::line_drive_t drive_of(input logic [3:0] a,
            input logic [3:0] m);
        drive_of = '{3'(stim_one_pkg::LINE_NONE), 16'h0000};
        case (a)
            stim_one_pkg::ACT_V_DP, stim_one_pkg::ACT_V_DM, stim_one_pkg::ACT_V_BOTH:
                drive_of = '{3'(stim_one_pkg::LINE_VOLT), volt_mv(m)};
            stim_one_pkg::ACT_R_DP, stim_one_pkg::ACT_R_DM, stim_one_pkg::ACT_R_BOTH:
                drive_of = '{3'(stim_one_pkg::LINE_RES), res_hohm(m)};
            stim_one_pkg::ACT_DIV_DP, stim_one_pkg::ACT_DIV_DM, stim_one_pkg::ACT_DIV_BOTH:
                drive_of = '{3'(stim_one_pkg::LINE_DIV), div_kohm(m)};
            stim_one_pkg::ACT_SHORT:
                drive_of = '{3'(stim_one_pkg::LINE_SHORT), stim_one_pkg::SHORT_MAX_OHM};
            default: ;
        endcase
    endfunction

    // read of the source/timer word never shows bit 7
    property p_top_bit_zero;
        @(posedge clk_i) disable iff (srst_i)
        (reg_addr_i == stim_one_pkg::SRC_TIMER_ADDR) |-> (reg_rdata_o[7] == 1'b0);
    endproperty
    a_top_bit_zero: assert property (p_top_bit_zero) else $error("bit 7 read as one");

    property p_reserved_src_kept;
        @(posedge clk_i) disable iff (srst_i)
        (ce_i && reg_wr_i && reg_addr_i == stim_one_pkg::SRC_TIMER_ADDR
            && src_reserved(reg_wdata_i[2:0])) |=> $stable(stimulus_one_source_sel);
    endproperty
    a_reserved_src_kept: assert property (p_reserved_src_kept) else $error("reserved src taken");

    property p_reserved_mag_kept;
        @(posedge clk_i) disable iff (srst_i)
        (ce_i && reg_wr_i && reg_addr_i == stim_one_pkg::RESPONSE_ADDR
            && reg_wdata_i[7:4] == stim_one_pkg::MAG_RSVD) |=> $stable(response_one_magnitude);
    endproperty
    a_reserved_mag_kept: assert property (p_reserved_mag_kept) else $error("reserved mag taken");

    property p_hold_immediate;
        @(posedge clk_i) disable iff (srst_i)
        (ce_i && state == stim_one_pkg::IDLE && step_start_i && stim_hit
            && stimulus_one_timer_kind) |=> (state == stim_one_pkg::HOLDING);
    endproperty
    a_hold_immediate: assert property (p_hold_immediate) else $error("hold not entered");

    property p_wait_enter;
        @(posedge clk_i) disable iff (srst_i)
        (ce_i && state == stim_one_pkg::IDLE && step_start_i && stim_hit
            && !stimulus_one_timer_kind && delay_ms != 7'h00)
            |=> (state == stim_one_pkg::WAIT_DELAY);
    endproperty
    a_wait_enter: assert property (p_wait_enter) else $error("delay not entered");

    property p_delay_map;
        @(posedge clk_i) (stimulus_one_delay_sel == 3'h6) |-> (delay_ms == 7'h50);
    endproperty
    a_delay_map: assert property (p_delay_map) else $error("80 ms code wrong");

    property p_window;
        @(posedge clk_i) disable iff (srst_i)
        (stimulus_one_source_sel == stim_one_pkg::SRC_DP_WINDOW)
            |-> (stim_hit == (sense_q.dp_above_fixed && !sense_q.dp_above_th));
    endproperty
    a_window: assert property (p_window) else $error("window decode wrong");

    property p_remove;
        @(posedge clk_i) disable iff (srst_i)
        (ce_i && state == stim_one_pkg::APPLIED && response_one_action == stim_one_pkg::ACT_REMOVE)
            |=> (port_dplus_line_o.kind == 3'(stim_one_pkg::LINE_NONE)
                && port_dminus_line_o.kind == 3'(stim_one_pkg::LINE_NONE));
    endproperty
    a_remove: assert property (p_remove) else $error("remove left a drive");
endmodule

/* test/stim_partner.sv */
// Purpose: portable device model driving the port comparator levels
// Assumes: comparators read low while the device is idle
// Notes: stimulus is a level held while active_i is high
`timescale 1ns/1ps
module stim_partner (
    input wire logic clk_i,
    input wire logic active_i,
    input wire logic [2:0] src_i,
    output stim_one_pkg::sense_t sense_o
);
    logic flip = 1'b0;
    // threshold level wanders so a vbus source cannot lean on it
    always @(posedge clk_i) begin
        flip <= ~flip;
    end
    // raise the comparator that the chosen source watches, and for vbus sources toggle dp_above_th too
    always_comb begin
        sense_o = '0;
        if (active_i) begin
            case (src_i)
                3'h0: sense_o.vbus_ready = 1'b1;
                3'h7: sense_o.vbus_present = 1'b1;
                3'h3: sense_o.dm_above_th = 1'b1;
                3'h2: sense_o.dp_above_fixed = 1'b1;
                default: sense_o.dp_above_th = 1'b1;
            endcase
            if (src_i == 3'h0 || src_i == 3'h7) begin
                sense_o.dp_above_th = flip;
            end
        end
    end
endmodule

/* test/tb_top.sv */
// Purpose: self-checking bench for the stimulus one step
// Assumes: MS_CYCLES shortened to 10 cycles per millisecond
// Notes: expected line states noted in a queue, popped when a step completes
`timescale 1ns/1ps
module tb_top;
    typedef struct {
        stim_one_pkg::line_drive_t dp;
        stim_one_pkg::line_drive_t dm;
        int lo;
        int hi;
        logic kind;
    } note_t;
    localparam int MSC = 10;
    logic clk_i = 1'b0, srst_i = 1'b1, reg_wr_i = 1'b0, step_start_i = 1'b0, active = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic [2:0] src = 3'h0;
    logic stimulus_seen_o, step_done_o, seen_q = 1'b0, done_q = 1'b0;
    stim_one_pkg::sense_t sense;
    stim_one_pkg::line_drive_t port_dplus_line_o, port_dminus_line_o, ep, em;
    note_t q[$];
    note_t n;
    int error_cnt = 0, checks = 0, cyc = 0, cnt = 0, j;
    integer seed = 32'h1a166ba5;
    logic [15:0] volt [15] = '{0, 400, 400, 400, 400, 500, 600, 700, 800, 900, 1400, 1600,
        1800, 2000, 2200};
    logic [15:0] res [15] = '{18, 100, 150, 200, 250, 300, 400, 430, 500, 600, 750, 800,
        1000, 1200, 1500};
    logic [15:0] dv [15] = '{93, 100, 125, 150, 200, 200, 200, 200, 93, 100, 125, 150,
        200, 200, 200};
    int dly [8] = '{0, 1, 5, 10, 20, 40, 80, 100};
    logic [2:0] srcs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    logic [3:0] acts [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h9, 4'ha, 4'hc,
        4'hd, 4'he, 4'hf};
    always #20 clk_i = ~clk_i;
    stim_one #(.MS_CYCLES(MSC)) dut_u (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1),
        .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .step_start_i(step_start_i), .sense_i(sense),
        .stimulus_seen_o(stimulus_seen_o), .step_done_o(step_done_o),
        .port_dplus_line_o(port_dplus_line_o), .port_dminus_line_o(port_dminus_line_o));
    stim_partner dev_u (.clk_i(clk_i), .active_i(active), .src_i(src), .sense_o(sense));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("errors=%0d checks=%0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        @(negedge clk_i);
        chk(reg_rdata_o, e);
    endtask
    // one random step: program, note the expectation, let the device stimulate
    task automatic step(input int i);
        logic [3:0] a;
        logic [3:0] m;
        logic [2:0] d;
        logic k;
        note_t t;
        a = acts[i % 13];
        m = 4'h1 + 4'($unsigned($random(seed)) % 14);
        d = 3'(i % 8);
        k = 1'((i / 8) % 2);
        src <= srcs[$unsigned($random(seed)) % 6];
        @(posedge clk_i);
        t.dp = (src != 3'h0 && ep.kind == 3'h1) ? '0 : ep;
        t.dm = (src != 3'h0 && em.kind == 3'h1) ? '0 : em;
        case (a)
            4'h0: begin t.dp = '0; t.dm = '0; end
            4'h1: t.dp = {3'h2, volt[m]};
            4'h2: t.dm = {3'h2, volt[m]};
            4'h3: begin t.dp = {3'h2, volt[m]}; t.dm = {3'h2, volt[m]}; end
            4'h4: t.dp = {3'h3, res[m]};
            4'h7: t.dm = {3'h3, res[m]};
            4'hd: begin t.dp = {3'h3, res[m]}; t.dm = {3'h3, res[m]}; end
            4'h6: t.dp = {3'h4, dv[m]};
            4'h9: t.dm = {3'h4, dv[m]};
            4'hc: begin t.dp = {3'h4, dv[m]}; t.dm = {3'h4, dv[m]}; end
            4'ha: begin t.dp = {3'h5, 16'h00c8}; t.dm = {3'h5, 16'h00c8}; end
            default: begin
                t.dp = (src == 3'h7) ? '0 : ep;
                t.dm = (src == 3'h7) ? '0 : em;
            end
        endcase
        t.lo = dly[d] * MSC - 1;
        t.hi = dly[d] * MSC + (k ? 9 : 3);
        t.kind = k;
        ep = t.dp;
        em = t.dm;
        q.push_back(t);
        wr(8'h41, {1'b0, k, d, src});
        wr(8'h42, {m, a});
        step_start_i <= 1'b1;
        active <= 1'b1;
        for (j = 0; j < 3000 && stimulus_seen_o !== 1'b1; j++) @(posedge clk_i);
        active <= 1'b0;
        for (j = 0; j < 3000 && step_done_o !== 1'b1; j++) @(posedge clk_i);
        step_start_i <= 1'b0;
        for (j = 0; j < 50 && stimulus_seen_o !== 1'b0; j++) @(posedge clk_i);
    endtask
    // watcher: applied-at-once check on detection, full compare on completion
    always @(negedge clk_i) begin
        cnt = cnt + 1;
        if (stimulus_seen_o === 1'b1 && seen_q !== 1'b1 && q.size() > 0) begin
            cnt = 0;
            if (q[0].kind === 1'b1) chk({port_dplus_line_o, port_dminus_line_o}, {q[0].dp, q[0].dm});
        end
        if (step_done_o === 1'b1 && done_q !== 1'b1 && q.size() > 0) begin
            n = q.pop_front();
            chk({port_dplus_line_o, port_dminus_line_o}, {n.dp, n.dm});
            chk(cnt >= n.lo && cnt <= n.hi, 1'b1);
        end
        seen_q = stimulus_seen_o;
        done_q = step_done_o;
    end
    // hang guard well above the longest expected run
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            test_done();
        end
    end
    initial begin
        ep = {3'h1, 16'h0000};
        em = {3'h1, 16'h0000};
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        rd(8'h41, 8'h00);
        rd(8'h42, 8'h00);
        chk({port_dplus_line_o, port_dminus_line_o}, {ep, em});
        wr(8'h41, 8'hff);
        rd(8'h41, 8'h7f);
        wr(8'h41, 8'h55);
        rd(8'h41, 8'h57);
        wr(8'h42, 8'h3c);
        wr(8'h42, 8'hf5);
        rd(8'h42, 8'h3c);
        wr(8'h42, 8'h8b);
        rd(8'h42, 8'h8c);
        rd(8'h40, 8'h00);
        for (int i = 0; i < 26; i++) step(i);
        chk(q.size(), 0);
        test_done();
    end
endmodule
